/* common/eprt_defines.vh */
`ifndef EPRT_DEFINES_VH
`define EPRT_DEFINES_VH

// Register byte offsets
`define EPRT_OFF_CTRL 8'h00
`define EPRT_OFF_LEAF 8'h04
`define EPRT_OFF_OPLO 8'h08
`define EPRT_OFF_OPHI 8'h0C
`define EPRT_OFF_MODE 8'h10
`define EPRT_OFF_SEGLIM 8'h14
`define EPRT_OFF_ATTR 8'h18
`define EPRT_OFF_VMAP 8'h1C
`define EPRT_OFF_BASE 8'h20
`define EPRT_OFF_RESULT 8'h24
`define EPRT_OFF_FLAGS 8'h28
`define EPRT_OFF_FAULT 8'h2C
`define EPRT_OFF_FADDR_LO 8'h30
`define EPRT_OFF_FADDR_HI 8'h34
`define EPRT_OFF_GPA 8'h38
`define EPRT_OFF_TRKCNT 8'h3C
`define EPRT_OFF_IRQ_STAT 8'h40
`define EPRT_OFF_IRQ_MASK 8'h44

// Leaf selector codes
`define EPRT_LEAF_REMOVE 32'h0000_0003
`define EPRT_LEAF_TRACK 32'h0000_000C

// Page types (3-bit field of ATTR)
`define EPRT_PT_CONTROL 3'h0
`define EPRT_PT_THREAD 3'h1
`define EPRT_PT_REGULAR 3'h2
`define EPRT_PT_VERSION 3'h3
`define EPRT_PT_TRIMMED 3'h4

// MODE field positions
`define EPRT_MODE_LONG 0
`define EPRT_MODE_GUEST 1
`define EPRT_MODE_VIRT 2
`define EPRT_MODE_CPL_LO 3

// ATTR field positions
`define EPRT_ATTR_MODIFIED 3
`define EPRT_ATTR_CHILD 4
`define EPRT_ATTR_VCHILD 5
`define EPRT_ATTR_ACTIVE 6
`define EPRT_ATTR_TRACKING 7
`define EPRT_ATTR_CONFLICT 8
`define EPRT_ATTR_TRK_CONFLICT 9

// Outcome kinds in FAULT[1:0]
`define EPRT_OUT_NONE 2'h0
`define EPRT_OUT_GP 2'h1
`define EPRT_OUT_PF 2'h2
`define EPRT_OUT_EXIT 2'h3

// Result and exit codes
`define EPRT_RES_OK 32'h0000_0000
`define EPRT_ERR_CHILD 32'h0000_0001
`define EPRT_ERR_ACTIVE 32'h0000_0002
`define EPRT_ERR_PREV_TRK 32'h0000_0011
`define EPRT_EXIT_CONFLICT 8'h01
`define EPRT_QUAL_PAGE 8'h01
`define EPRT_EXIT_ERROR 4'h0

// Interrupt status bits
`define EPRT_IRQ_DONE 0
`define EPRT_IRQ_FAULT 1
`define EPRT_IRQ_REMOVED 2
`define EPRT_IRQ_TRACK 3

// Reset values
`define EPRT_RST_MODE 32'h0000_0001
`define EPRT_RST_VMAP 32'h0000_0000

`endif

/* src/eprt_core.v */
`timescale 1ns/1ps
`include "eprt_defines.vh"

module eprt_core (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire pslverr,
    output reg [31:0] prdata,
    // Interrupt
    output wire irq
);

    reg [31:0] leaf_q;
    reg [31:0] op_lo_q;
    reg [31:0] op_hi_q;
    reg [31:0] mode_q;
    reg [31:0] seglim_q;
    reg [31:0] attr_q;
    reg [31:0] vmap_q;
    reg [31:0] base_q;
    reg [31:0] result_q;
    reg [5:0] flags_q;
    reg [31:0] fault_q;
    reg [31:0] faddr_lo_q;
    reg [31:0] faddr_hi_q;
    reg [31:0] gpa_q;
    reg [31:0] trkcnt_q;
    reg [3:0] irq_stat_q;
    reg [3:0] irq_mask_q;
    reg start_q;

    wire wr_en = psel & penable & pwrite;
    wire rd_en = psel & penable & ~pwrite;
    reg addr_ok;

    // Single-cycle slave: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign irq = |(irq_stat_q & irq_mask_q);

    // Decode of operand and context
    wire [63:0] op_addr = {op_hi_q, op_lo_q};
    wire long_mode = mode_q[`EPRT_MODE_LONG];
    wire guest_virt = mode_q[`EPRT_MODE_GUEST] & mode_q[`EPRT_MODE_VIRT];
    wire [1:0] cpl = mode_q[`EPRT_MODE_CPL_LO+1:`EPRT_MODE_CPL_LO];
    wire [2:0] ptype = attr_q[2:0];
    wire modified = attr_q[`EPRT_ATTR_MODIFIED];
    wire [51:0] page_num = op_addr[63:12];
    wire [51:0] page_off = page_num - {20'h0_0000, base_q};
    wire resident = (page_off[51:5] == 47'h0);
    wire [4:0] pidx = page_off[4:0];
    wire page_valid = vmap_q[pidx];
    wire trim_clean = (ptype == `EPRT_PT_TRIMMED) & ~modified;

    // Canonical in 64-bit mode, inside segment limit in 32-bit mode
    wire canon_bad = long_mode & ~((&op_addr[63:47]) | ~(|op_addr[63:47]));
    wire limit_bad = ~long_mode & (op_lo_q > seglim_q);

    // Execution outcome, evaluated in the start cycle
    reg [1:0] out_kind;
    reg [31:0] res_d;
    reg zf_d;
    reg clear_d;
    reg track_d;
    reg [7:0] qual_d;
    reg [7:0] reason_d;

    always @* begin
        out_kind = `EPRT_OUT_NONE;
        res_d = `EPRT_RES_OK;
        zf_d = 1'b0;
        clear_d = 1'b0;
        track_d = 1'b0;
        qual_d = 8'h00;
        reason_d = 8'h00;
        if (leaf_q != `EPRT_LEAF_REMOVE && leaf_q != `EPRT_LEAF_TRACK) begin
            out_kind = `EPRT_OUT_GP;
        end else if (cpl != 2'h0) begin
            out_kind = `EPRT_OUT_GP;
        end else if (canon_bad | limit_bad) begin
            out_kind = `EPRT_OUT_GP;
        end else if (op_addr[11:0] != 12'h000) begin
            out_kind = `EPRT_OUT_GP;
        end else if (~resident) begin
            out_kind = `EPRT_OUT_PF;
        end else if (leaf_q == `EPRT_LEAF_REMOVE) begin
            // Only a same-page user counts: accept, add and tracking groups never block
            if (attr_q[`EPRT_ATTR_CONFLICT]) begin
                if (guest_virt) begin
                    out_kind = `EPRT_OUT_EXIT;
                    reason_d = `EPRT_EXIT_CONFLICT;
                    qual_d = `EPRT_QUAL_PAGE;
                end else begin
                    out_kind = `EPRT_OUT_GP;
                end
            end else if (~page_valid) begin
                res_d = `EPRT_RES_OK;
            end else if (trim_clean | (ptype == `EPRT_PT_VERSION)) begin
                clear_d = 1'b1;
            end else if (ptype == `EPRT_PT_CONTROL) begin
                if (attr_q[`EPRT_ATTR_CHILD]) begin
                    zf_d = 1'b1;
                    res_d = `EPRT_ERR_CHILD;
                end else if (guest_virt & attr_q[`EPRT_ATTR_VCHILD]) begin
                    zf_d = 1'b1;
                    res_d = `EPRT_ERR_CHILD;
                end else begin
                    clear_d = 1'b1;
                end
            end else if (attr_q[`EPRT_ATTR_ACTIVE]) begin
                zf_d = 1'b1;
                res_d = `EPRT_ERR_ACTIVE;
            end else if (ptype == `EPRT_PT_REGULAR || ptype == `EPRT_PT_THREAD ||
                         ptype == `EPRT_PT_TRIMMED) begin
                clear_d = 1'b1;
            end
        end else begin
            // Shared access: only another tracking user on this page conflicts
            if (attr_q[`EPRT_ATTR_TRK_CONFLICT]) begin
                out_kind = `EPRT_OUT_GP;
            end else if (~page_valid || ptype != `EPRT_PT_CONTROL) begin
                out_kind = `EPRT_OUT_PF;
            end else if (attr_q[`EPRT_ATTR_TRACKING]) begin
                zf_d = 1'b1;
                res_d = `EPRT_ERR_PREV_TRK;
            end else begin
                track_d = 1'b1;
            end
        end
    end

    // Register read decode
    always @* begin
        addr_ok = 1'b1;
        prdata = 32'h0000_0000;
        case (paddr)
            `EPRT_OFF_CTRL: prdata = 32'h0000_0000;
            `EPRT_OFF_LEAF: prdata = leaf_q;
            `EPRT_OFF_OPLO: prdata = op_lo_q;
            `EPRT_OFF_OPHI: prdata = op_hi_q;
            `EPRT_OFF_MODE: prdata = mode_q;
            `EPRT_OFF_SEGLIM: prdata = seglim_q;
            `EPRT_OFF_ATTR: prdata = attr_q;
            `EPRT_OFF_VMAP: prdata = vmap_q;
            `EPRT_OFF_BASE: prdata = base_q;
            `EPRT_OFF_RESULT: prdata = result_q;
            `EPRT_OFF_FLAGS: prdata = {26'h000_0000, flags_q};
            `EPRT_OFF_FAULT: prdata = fault_q;
            `EPRT_OFF_FADDR_LO: prdata = faddr_lo_q;
            `EPRT_OFF_FADDR_HI: prdata = faddr_hi_q;
            `EPRT_OFF_GPA: prdata = gpa_q;
            `EPRT_OFF_TRKCNT: prdata = trkcnt_q;
            `EPRT_OFF_IRQ_STAT: prdata = {28'h000_0000, irq_stat_q};
            `EPRT_OFF_IRQ_MASK: prdata = {28'h000_0000, irq_mask_q};
            default: addr_ok = 1'b0;
        endcase
        if (~rd_en) begin
            prdata = 32'h0000_0000;
        end
    end

    // Software-written context and start pulse
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            leaf_q <= 32'h0000_0000;
            op_lo_q <= 32'h0000_0000;
            op_hi_q <= 32'h0000_0000;
            mode_q <= `EPRT_RST_MODE;
            seglim_q <= 32'h0000_0000;
            attr_q <= 32'h0000_0000;
            base_q <= 32'h0000_0000;
            gpa_q <= 32'h0000_0000;
            irq_mask_q <= 4'h0;
            start_q <= 1'b0;
        end else begin
            start_q <= wr_en & (paddr == `EPRT_OFF_CTRL) & pwdata[0];
            if (wr_en) begin
                case (paddr)
                    `EPRT_OFF_LEAF: leaf_q <= pwdata;
                    `EPRT_OFF_OPLO: op_lo_q <= pwdata;
                    `EPRT_OFF_OPHI: op_hi_q <= pwdata;
                    `EPRT_OFF_MODE: mode_q <= {27'h000_0000, pwdata[4:0]};
                    `EPRT_OFF_SEGLIM: seglim_q <= pwdata;
                    `EPRT_OFF_ATTR: attr_q <= {22'h00_0000, pwdata[9:0]};
                    `EPRT_OFF_BASE: base_q <= pwdata;
                    `EPRT_OFF_GPA: gpa_q <= pwdata;
                    `EPRT_OFF_IRQ_MASK: irq_mask_q <= pwdata[3:0];
                    // Control and status words are handled elsewhere; the start pulse must survive
                    default: ;
                endcase
            end
        end
    end

    // Valid map: the hardware clear lands after any software write in the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vmap_q <= `EPRT_RST_VMAP;
        end else begin
            if (wr_en && paddr == `EPRT_OFF_VMAP) begin
                vmap_q <= pwdata;
            end
            if (start_q && out_kind == `EPRT_OUT_NONE && clear_d) begin
                vmap_q[pidx] <= 1'b0;
            end
        end
    end

    // Results; faults leave result and flags untouched
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_q <= 32'h0000_0000;
            flags_q <= 6'h00;
            fault_q <= 32'h0000_0000;
            faddr_lo_q <= 32'h0000_0000;
            faddr_hi_q <= 32'h0000_0000;
            trkcnt_q <= 32'h0000_0000;
        end else if (start_q) begin
            fault_q <= {8'h00, qual_d, reason_d, `EPRT_EXIT_ERROR, 2'h0, out_kind};
            faddr_lo_q <= (out_kind == `EPRT_OUT_NONE) ? 32'h0000_0000 : op_lo_q;
            faddr_hi_q <= (out_kind == `EPRT_OUT_NONE) ? 32'h0000_0000 : op_hi_q;
            if (out_kind == `EPRT_OUT_NONE) begin
                result_q <= res_d;
                flags_q <= {5'h00, zf_d};
                if (track_d) begin
                    trkcnt_q <= trkcnt_q + 32'h0000_0001;
                end
            end
        end
    end

    // Sticky interrupt status; a new event beats a write-one clear
    wire [3:0] ev;
    assign ev[`EPRT_IRQ_DONE] = start_q & (out_kind == `EPRT_OUT_NONE);
    assign ev[`EPRT_IRQ_FAULT] = start_q & (out_kind != `EPRT_OUT_NONE);
    assign ev[`EPRT_IRQ_REMOVED] = start_q & (out_kind == `EPRT_OUT_NONE) & clear_d;
    assign ev[`EPRT_IRQ_TRACK] = start_q & (out_kind == `EPRT_OUT_NONE) & track_d;
    wire [3:0] w1c = (wr_en && paddr == `EPRT_OFF_IRQ_STAT) ? pwdata[3:0] : 4'h0;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= 4'h0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~w1c) | ev;
        end
    end

endmodule

/* sim/eprt_chk_sva.sv */
`timescale 1ns/1ps
module eprt_chk (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    // Interrupt
    input wire logic irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd;
    logic [31:0] res_q;
    logic res_v_q;
    logic [31:0] mask_q;
    assign rd = psel && penable && !pwrite;
    // Last result read; dropped at a start so stale codes never pair with new flags
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_q <= 32'h0;
            res_v_q <= 1'b0;
            mask_q <= 32'h0;
        end else if (psel && penable) begin
            if (rd && paddr == 8'h24) begin
                res_q <= prdata;
                res_v_q <= 1'b1;
            end
            if (pwrite && paddr == 8'h00) res_v_q <= 1'b0;
            if (pwrite && paddr == 8'h44) mask_q <= pwdata;
        end
    end
    flags_clear_a: assert property (rd && paddr == 8'h28 |-> prdata[5:1] == 5'h00)
        else $error("side flags not clear");
    exit_err_a: assert property (rd && paddr == 8'h2C |-> prdata[5:2] == 4'h0)
        else $error("exit error not zero");
    exit_code_a: assert property (rd && paddr == 8'h2C && prdata[1:0] == 2'h3
        |-> prdata[23:8] == 16'h0101) else $error("exit reason or qualifier wrong");
    res_code_a: assert property (rd && paddr == 8'h24
        |-> prdata inside {32'h0, 32'h1, 32'h2, 32'h11}) else $error("unknown result code");
    zf_err_a: assert property (rd && paddr == 8'h28 && res_v_q && res_q != 32'h0
        |-> prdata[0]) else $error("zero flag clear on error");
    zf_ok_a: assert property (rd && paddr == 8'h28 && res_v_q && res_q == 32'h0
        |-> !prdata[0]) else $error("zero flag set on success");
    irq_mask_a: assert property (mask_q == 32'h0 |-> !irq)
        else $error("interrupt with all sources masked");
    // Only aligned words up to the mask register are mapped
    unmapped_addr_a: assert property (psel && penable
        |-> pslverr == (paddr > 8'h44 || paddr[1:0] != 2'h0))
        else $error("slave error does not match address map");
    c_start: cover property (psel && penable && pwrite && paddr == 8'h00);
    c_irq: cover property ($rose(irq));
    c_exit: cover property (rd && paddr == 8'h2C && prdata[1:0] == 2'h3);
endmodule
bind eprt_core eprt_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .irq(irq));

/* sim/eprt_sw_model.sv */
`timescale 1ns/1ps
module eprt_sw_model (
    // Clock
    input wire logic pclk,
    // APB master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata
);
    // Idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // One transfer; request held until pready is seen high, only the bench timeout ends a hang
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Privilege level rides in the mode word; refusals pass a nonzero level
    task automatic issue(input logic [31:0] leaf, input logic [31:0] mode);
        logic [31:0] q;
        xfer(1'b1, 8'h10, mode, q);
        xfer(1'b1, 8'h04, leaf, q);
        xfer(1'b1, 8'h00, 32'h1, q);
    endtask
endmodule

/* sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    wire psel, penable, pwrite, pready, pslverr, irq;
    wire [7:0] paddr;
    wire [31:0] pwdata, prdata;
    int fail_count = 0;
    int checks = 0;
    localparam logic [31:0] RM = 32'h3;
    localparam logic [31:0] TR = 32'hC;
    localparam logic [31:0] PG = 32'h0010_0000; // First page of the cache, base 0x100
    eprt_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .irq(irq));
    eprt_sw_model u_sw (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        u_sw.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        u_sw.xfer(1'b0, a, 32'h0, q);
    endtask
    // Page context first, then the start
    task automatic run(input logic [31:0] lf, md, at, op, hi, vm);
        wr(8'h08, op);
        wr(8'h0C, hi);
        wr(8'h18, at);
        wr(8'h1C, vm);
        u_sw.issue(lf, md);
    endtask
    task automatic outcome(input logic [31:0] res, input logic [31:0] vm);
        logic [31:0] q;
        rd(8'h24, q);
        chk("result", res, q);
        rd(8'h28, q);
        chk("flags", {31'h0, res != 32'h0}, q);
        rd(8'h2C, q);
        chk("fault", 32'h0, q);
        rd(8'h1C, q);
        chk("valid map", vm, q);
    endtask
    task automatic fault(input logic [31:0] kind, input logic [31:0] addr);
        logic [31:0] q;
        rd(8'h2C, q);
        chk("fault", kind, q);
        rd(8'h30, q);
        chk("fault addr", addr, q);
    endtask
    task automatic t_remove;
        run(RM, 32'h1, 32'h3, PG, 32'h0, 32'h1); outcome(32'h0, 32'h0);
        run(RM, 32'h1, 32'h4, PG, 32'h0, 32'h1); outcome(32'h0, 32'h0);
        run(RM, 32'h1, 32'h42, PG, 32'h0, 32'h0); outcome(32'h0, 32'h0);
        run(RM, 32'h1, 32'h10, PG, 32'h0, 32'h1); outcome(32'h1, 32'h1);
        run(RM, 32'h1, 32'h0, PG, 32'h0, 32'h1); outcome(32'h0, 32'h0);
        run(RM, 32'h7, 32'h20, PG, 32'h0, 32'h1); outcome(32'h1, 32'h1);
        run(RM, 32'h1, 32'h20, PG, 32'h0, 32'h1); outcome(32'h0, 32'h0);
        run(RM, 32'h1, 32'h42, PG, 32'h0, 32'h1); outcome(32'h2, 32'h1);
        run(RM, 32'h1, 32'h1, PG, 32'h0, 32'h1); outcome(32'h0, 32'h0);
        run(RM, 32'h1, 32'hC, PG, 32'h0, 32'h1); outcome(32'h0, 32'h0);
        run(RM, 32'h1, 32'h202, PG + 32'h1F000, 32'h0, 32'h8000_0000);
        outcome(32'h0, 32'h0);
        $display("remove tests done");
    endtask
    task automatic t_faults;
        run(RM, 32'h1, 32'h2, PG + 32'h800, 32'h0, 32'h1); fault(32'h1, PG + 32'h800);
        run(RM, 32'h1, 32'h2, PG + 32'h20000, 32'h0, 32'h1); fault(32'h2, PG + 32'h20000);
        run(RM, 32'h7, 32'h102, PG, 32'h0, 32'h1); fault(32'h0001_0103, PG);
        run(RM, 32'h1, 32'h102, PG, 32'h0, 32'h1); fault(32'h1, PG);
        run(RM, 32'h1, 32'h2, PG, 32'h0001_0000, 32'h1); fault(32'h1, PG);
        run(RM, 32'h9, 32'h2, PG, 32'h0, 32'h1); fault(32'h1, PG);
        $display("fault tests done");
    endtask
    task automatic t_track;
        logic [31:0] q;
        run(TR, 32'h1, 32'h0, PG, 32'h0, 32'h1); outcome(32'h0, 32'h1);
        rd(8'h3C, q);
        chk("track count", 32'h1, q);
        run(TR, 32'h1, 32'h80, PG, 32'h0, 32'h1); outcome(32'h11, 32'h1);
        run(TR, 32'h1, 32'h200, PG, 32'h0, 32'h1); fault(32'h1, PG);
        run(TR, 32'h9, 32'h0, PG, 32'h0, 32'h1); fault(32'h1, PG);
        wr(8'h14, 32'hFFFF_FFFF);
        run(TR, 32'h0, 32'h0, PG, 32'h0, 32'h1); outcome(32'h0, 32'h1);
        wr(8'h14, PG - 32'h1);
        run(RM, 32'h0, 32'h2, PG, 32'h0, 32'h1); fault(32'h1, PG);
        $display("tracking tests done");
    endtask
    // Sticky status, mask and clear-by-one, plus an unmapped read
    task automatic t_irq;
        logic [31:0] q;
        wr(8'h40, 32'hF);
        wr(8'h44, 32'h4);
        run(RM, 32'h1, 32'h2, PG, 32'h0, 32'h1);
        rd(8'h40, q);
        chk("irq status", 32'h5, q);
        chk("irq", 32'h1, {31'h0, irq});
        wr(8'h40, 32'h4);
        rd(8'h40, q);
        chk("irq status", 32'h1, q);
        chk("irq", 32'h0, {31'h0, irq});
        wr(8'h44, 32'h1);
        rd(8'h80, q);
        chk("unmapped", 32'h0, q);
        chk("irq", 32'h1, {31'h0, irq});
        $display("interrupt tests done");
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // 40 MHz clock
    initial begin
        forever #12.5 pclk = ~pclk;
    end
    // Run is near 800 cycles; the 20000-cycle limit, some 25 times that, means a hang
    initial begin
        #500000;
        fail_count++;
        close_out;
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        wr(8'h20, 32'h0000_0100);
        t_remove;
        t_faults;
        t_track;
        t_irq;
        close_out;
    end
endmodule
